// File: hdl/lpt_pkg.sv
// lpt_pkg.sv: constants, types and per-panel timing sets of the panel timing generator
package lpt_pkg;

   // -------------------------------------------------------------------------
   // frame geometry and pixel format
   // -------------------------------------------------------------------------
   localparam logic [9:0] LPT_H_ACTIVE   = 10'd640;
   localparam logic [9:0] LPT_V_ACTIVE   = 10'd480;
   localparam logic [9:0] LPT_H_BACK     = 10'd48;    // de rises 48 clocks after hsync
   localparam logic [9:0] LPT_H_FRONT    = 10'd16;    // de falls 16 clocks before hsync
   localparam int         LPT_COLOUR_W   = 6;

   // -------------------------------------------------------------------------
   // clock figures
   // -------------------------------------------------------------------------
   localparam int LPT_CLK_PERIOD_PS = 10000;          // pclk, 100 MHz
   localparam int LPT_PIX_PERIOD_PS = 39720;          // 25.18 MHz pixel clock
   // shortest divider whose period is not below the pixel period
   localparam int LPT_PIX_DIV = (LPT_PIX_PERIOD_PS + LPT_CLK_PERIOD_PS - 1) / LPT_CLK_PERIOD_PS;
   localparam int    LPT_IDLE_MIN    = 10;            // keypad idle time, minutes
   localparam longint LPT_IDLE_CYCLES =
      longint'(LPT_IDLE_MIN) * 64'd60_000_000_000_000 / longint'(LPT_CLK_PERIOD_PS); // ps per min
   localparam int LPT_DIM_STEP_NS   = 1000;           // dimmer wiper step spacing
   localparam int LPT_DIM_STEP_CYC  = LPT_DIM_STEP_NS * 1000 / LPT_CLK_PERIOD_PS;
   localparam int LPT_ID_SETTLE_CYC = 16;             // jumper settle before capture

   // -------------------------------------------------------------------------
   // dimmer
   // -------------------------------------------------------------------------
   localparam logic [6:0] LPT_DIM_MAX = 7'd99;        // 100 wiper positions, 0..99

   // -------------------------------------------------------------------------
   // register map, byte addresses, and reset values
   // -------------------------------------------------------------------------
   localparam logic [11:0] LPT_ADDR_CTRL   = 12'h000;
   localparam logic [11:0] LPT_ADDR_BRIGHT = 12'h004;
   localparam logic [11:0] LPT_ADDR_COLOUR = 12'h008;
   localparam logic [11:0] LPT_ADDR_STATUS = 12'h00C;
   localparam logic [11:0] LPT_ADDR_FRAMES = 12'h010;
   localparam int LPT_CTRL_LAMP  = 0;
   localparam int LPT_CTRL_VIDEO = 1;
   localparam int LPT_CTRL_SOLID = 2;
   localparam logic [2:0]  LPT_CTRL_RST   = 3'h0;
   localparam logic [6:0]  LPT_BRIGHT_RST = 7'd99;
   localparam logic [17:0] LPT_COLOUR_RST = 18'h0_0000;

   // -------------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [LPT_COLOUR_W-1:0] red;
      logic [LPT_COLOUR_W-1:0] green;
      logic [LPT_COLOUR_W-1:0] blue;
   } lpt_rgb_t;

   typedef struct packed {
      logic [9:0] hsw;      // hsync width, pixel clocks
      logic [9:0] vsw;      // vsync width, lines
      logic [9:0] vback;    // lines from vsync end to first row
      logic [9:0] vfront;   // lines after last row
      logic       hpol;     // active level of hsync
      logic       vpol;     // active level of vsync
   } lpt_timing_t;

   // -------------------------------------------------------------------------
   // panel identification codes and their timing sets
   // -------------------------------------------------------------------------
   localparam logic [3:0] LPT_ID_PANEL_A = 4'b0001;
   localparam logic [3:0] LPT_ID_PANEL_B = 4'b0010;
   localparam lpt_timing_t LPT_TM_PANEL_A = '{10'd96, 10'd2, 10'd33, 10'd10, 1'b0, 1'b0};
   localparam lpt_timing_t LPT_TM_PANEL_B = '{10'd96, 10'd2, 10'd32, 10'd11, 1'b0, 1'b0};
   localparam lpt_timing_t LPT_TM_SAFE    = '{10'd96, 10'd2, 10'd33, 10'd10, 1'b0, 1'b0};

   function automatic lpt_timing_t lpt_timing(input logic [3:0] id);
      case (id)
         LPT_ID_PANEL_A: lpt_timing = LPT_TM_PANEL_A;
         LPT_ID_PANEL_B: lpt_timing = LPT_TM_PANEL_B;
         default:        lpt_timing = LPT_TM_SAFE;
      endcase
   endfunction

endpackage

// File: hdl/lpt_sync2.sv
// lpt_sync2.sv: two-flop synchroniser for pins from outside the pclk domain
`timescale 1ns/1ps
module lpt_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // lpt_sync2

// File: hdl/lpt_dimmer.sv
// lpt_dimmer.sv: steps a 100-position digital dimmer wiper toward a target
`timescale 1ns/1ps
module lpt_dimmer
   import lpt_pkg::*;
#(
   parameter int STEP_CYC = LPT_DIM_STEP_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [6:0] target,
   output logic      [6:0] pos,
   output logic            homed,
   output logic            dim_up,
   output logic            dim_step_n
);
   logic [15:0] gap;
   logic [6:0]  home_cnt;

   // wiper position is unknown at power-up: walk it fully down first,
   // then track the target one step per spacing interval
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap        <= '0;
         home_cnt   <= '0;
         homed      <= 1'b0;
         pos        <= '0;
         dim_up     <= 1'b0;
         dim_step_n <= 1'b1;
      end else begin
         dim_step_n <= 1'b1;
         if (gap != 16'd0) begin
            gap <= gap - 16'd1;
         end else if (!homed) begin
            dim_up     <= 1'b0;
            dim_step_n <= 1'b0;
            gap        <= 16'(STEP_CYC - 1);
            home_cnt   <= home_cnt + 7'd1;
            homed      <= (home_cnt == LPT_DIM_MAX);
         end else if (target != pos) begin
            dim_up     <= (target > pos);
            dim_step_n <= 1'b0;
            gap        <= 16'(STEP_CYC - 1);
            pos        <= (target > pos) ? pos + 7'd1 : pos - 7'd1;
         end
      end
   end
endmodule // lpt_dimmer

// File: hdl/lpt_top.sv
// lpt_top.sv: lcd panel timing generator with apb registers and backlight control
`timescale 1ns/1ps

// Notes on behaviour
// - 640 by 480 frame, one word per pixel
// - pixel word is three 6-bit colour fields
// - scan left to right, top to bottom
// - vsync starts frame at upper left
// - each hsync after vsync starts next row
// - first pixel on enable, then 639 more
// - pixel clock about 25.18 MHz
// - after row 480, next vsync, repeat
// - data 48 clocks after hsync, 16 before
// - enable 4-48 after, 2-16 before hsync
// - always run panel in enable-gated mode
// - never rely on fixed-offset timing
// - sample panel id at power-up, pick timing
// - send lamp on/off and brightness
// - dim to half after idle, restore on key
// - brightness via 100-step digital dimmer
module lpt_top
   import lpt_pkg::*;
#(
   parameter longint IDLE_CYCLES = LPT_IDLE_CYCLES,
   parameter int     PIX_DIV     = LPT_PIX_DIV,
   parameter int     DIM_STEP    = LPT_DIM_STEP_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic      [31:0] prdata,
   output logic             pslverr,
   // pins from the panel interface board and keypad
   input  wire logic [3:0]  panel_id,
   input  wire logic        key_pressed,
   // pixel source, same clock domain
   input  wire lpt_rgb_t    pix_in,
   output logic             pix_take,
   // panel link
   output logic             lcd_clk,
   output logic             lcd_hsync,
   output logic             lcd_vsync,
   output logic             lcd_de,
   output lpt_rgb_t         lcd_rgb,
   // backlight inverter and dimmer
   output logic             lamp_on,
   output logic             dim_up,
   output logic             dim_step_n
);

   // -------------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------------
   localparam int HALF = PIX_DIV / 2;

   logic [3:0]    id_sync;
   logic          key_sync;
   logic          key_prev;
   logic [4:0]    settle;
   logic          id_valid;
   logic [3:0]    id_latched;
   lpt_timing_t   tm;

   logic [2:0]    ctrl;
   logic [6:0]    bright;
   lpt_rgb_t      colour;
   logic [15:0]   frames;
   logic [31:0]   next_rdata;
   logic          next_err;
   logic          wr_en;

   logic [7:0]    div_cnt;
   logic [7:0]    next_div;
   logic          pix_tick;
   logic          running;
   logic [9:0]    hcnt;
   logic [9:0]    vcnt;
   logic [9:0]    htotal;
   logic [9:0]    vtotal;
   logic [9:0]    hde_start;
   logic [9:0]    vde_start;
   logic          de_now;

   logic [35:0]   idle_cnt;
   logic          dimmed;
   logic [6:0]    dim_target;
   logic [6:0]    dim_pos;
   logic          dim_homed;

   // -------------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------------
   // jumper straps and keypad are asynchronous to pclk
   lpt_sync2 #(
      .WIDTH (5)
   ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({key_pressed, panel_id}),
      .q     ({key_sync, id_sync})
   );

   // -------------------------------------------------------------------------
   // panel identification
   // -------------------------------------------------------------------------
   // capture after a settle delay so the straps are read clean, once only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle     <= '0;
         id_valid   <= 1'b0;
         id_latched <= '0;
         tm         <= LPT_TM_SAFE;
      end else if (!id_valid) begin
         settle <= settle + 5'd1;
         if (settle == 5'(LPT_ID_SETTLE_CYC - 1)) begin
            id_valid   <= 1'b1;
            id_latched <= id_sync;
            tm         <= lpt_timing(id_sync);
         end
      end
   end

   // per-panel totals; porches inside a line are fixed for every panel
   assign hde_start = tm.hsw + LPT_H_BACK;
   assign htotal    = hde_start + LPT_H_ACTIVE + LPT_H_FRONT;
   assign vde_start = tm.vsw + tm.vback;
   assign vtotal    = vde_start + LPT_V_ACTIVE + tm.vfront;

   // -------------------------------------------------------------------------
   // apb slave
   // -------------------------------------------------------------------------
   // one wait state: data and pready come from flops on the second access cycle
   assign wr_en = psel && penable && pready && pwrite;

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      case (paddr)
         LPT_ADDR_CTRL:   next_rdata = {29'h0, ctrl};
         LPT_ADDR_BRIGHT: next_rdata = {25'h0, bright};
         LPT_ADDR_COLOUR: next_rdata = {14'h0, colour};
         LPT_ADDR_STATUS: next_rdata = {16'h0, dim_homed, dim_pos, dimmed,
                                        (vcnt < vde_start), id_valid, 1'b0, id_latched};
         LPT_ADDR_FRAMES: next_rdata = {16'h0, frames};
         default:         next_err   = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && next_err;
         if (psel && penable && !pready && !pwrite) begin
            prdata <= next_rdata;
         end
      end
   end

   // writable registers; status and frame count are read only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl   <= LPT_CTRL_RST;
         bright <= LPT_BRIGHT_RST;
         colour <= LPT_COLOUR_RST;
      end else if (wr_en) begin
         case (paddr)
            LPT_ADDR_CTRL:   ctrl   <= pwdata[2:0];
            LPT_ADDR_BRIGHT: bright <= (pwdata[6:0] > LPT_DIM_MAX) ? LPT_DIM_MAX : pwdata[6:0];
            LPT_ADDR_COLOUR: colour <= pwdata[17:0];
            default:         ;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // pixel clock divider
   // -------------------------------------------------------------------------
   // panel samples on the rising edge of lcd_clk; we update on its falling edge
   assign next_div = (div_cnt == 8'(PIX_DIV - 1)) ? 8'd0 : div_cnt + 8'd1;
   assign pix_tick = (div_cnt == 8'(HALF - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= '0;
         lcd_clk <= 1'b0;
      end else begin
         div_cnt <= next_div;
         lcd_clk <= (next_div < 8'(HALF)) && running;
      end
   end

   // -------------------------------------------------------------------------
   // raster counters
   // -------------------------------------------------------------------------
   assign running = id_valid && ctrl[LPT_CTRL_VIDEO];

   // columns inner, rows outer: left to right, top to bottom, then wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hcnt   <= '0;
         vcnt   <= '0;
         frames <= '0;
      end else if (!running) begin
         hcnt <= '0;
         vcnt <= '0;
      end else if (pix_tick) begin
         if (hcnt == htotal - 10'd1) begin
            hcnt <= '0;
            if (vcnt == vtotal - 10'd1) begin
               vcnt   <= '0;
               frames <= frames + 16'd1;
            end else begin
               vcnt <= vcnt + 10'd1;
            end
         end else begin
            hcnt <= hcnt + 10'd1;
         end
      end
   end

   // enable window: 640 columns of 480 rows, porches 48 and 16 around it
   assign de_now = (hcnt >= hde_start) && (hcnt < hde_start + LPT_H_ACTIVE) &&
                   (vcnt >= vde_start) && (vcnt < vde_start + LPT_V_ACTIVE);

   // -------------------------------------------------------------------------
   // panel outputs
   // -------------------------------------------------------------------------
   // enable is always driven per row, so panels without fixed-offset mode work
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcd_hsync <= 1'b1;
         lcd_vsync <= 1'b1;
         lcd_de    <= 1'b0;
         lcd_rgb   <= '0;
         pix_take  <= 1'b0;
      end else begin
         pix_take <= 1'b0;
         if (!running) begin
            lcd_hsync <= !tm.hpol;
            lcd_vsync <= !tm.vpol;
            lcd_de    <= 1'b0;
            lcd_rgb   <= '0;
         end else if (pix_tick) begin
            lcd_hsync <= (hcnt < tm.hsw) ? tm.hpol : !tm.hpol;
            lcd_vsync <= (vcnt < tm.vsw) ? tm.vpol : !tm.vpol;
            lcd_de    <= de_now;
            if (de_now) begin
               lcd_rgb  <= ctrl[LPT_CTRL_SOLID] ? colour : pix_in;
               pix_take <= !ctrl[LPT_CTRL_SOLID];
            end else begin
               lcd_rgb <= '0;                        // blanking drives darkest value
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // keypad idle timer
   // -------------------------------------------------------------------------
   // a long idle count is a parameter so simulation can shorten it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_prev <= 1'b0;
         idle_cnt <= '0;
         dimmed   <= 1'b0;
      end else begin
         key_prev <= key_sync;
         if (key_sync && !key_prev) begin
            idle_cnt <= '0;
            dimmed   <= 1'b0;
         end else if (idle_cnt == 36'(IDLE_CYCLES - 1)) begin
            dimmed <= 1'b1;
         end else begin
            idle_cnt <= idle_cnt + 36'd1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // backlight
   // -------------------------------------------------------------------------
   // half of the programmed level keeps the screen readable while saving lamp life
   assign dim_target = dimmed ? (bright >> 1) : bright;

   lpt_dimmer #(
      .STEP_CYC (DIM_STEP)
   ) u_dimmer (
      .clk        (pclk),
      .rst_n      (presetn),
      .target     (dim_target),
      .pos        (dim_pos),
      .homed      (dim_homed),
      .dim_up     (dim_up),
      .dim_step_n (dim_step_n)
   );

   // lamp waits for the panel to be identified
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lamp_on <= 1'b0;
      end else begin
         lamp_on <= id_valid && ctrl[LPT_CTRL_LAMP];
      end
   end

endmodule // lpt_top

// File: dv/lpt_top_monitor.sv
// lpt_top_monitor.sv: port checker for the panel timing generator
`timescale 1ns/1ps
module lpt_top_monitor
   import lpt_pkg::*;
#(
   parameter int PIX_DIV = LPT_PIX_DIV
) (
   input wire logic     pclk,
   input wire logic     presetn,
   input wire logic     psel,
   input wire logic     penable,
   input wire logic     pready,
   input wire logic     pslverr,
   input wire lpt_rgb_t pix_in,
   input wire logic     pix_take,
   input wire logic     lcd_clk,
   input wire logic     lcd_hsync,
   input wire logic     lcd_de,
   input wire lpt_rgb_t lcd_rgb,
   input wire logic     dim_step_n
);
   int de_cnt;
   int hs_cnt;
   int de_off;
   int ck_hi;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ------
   // run-length helpers
   // ------
   // de_off saturates so the first hsync after start-up is ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         de_cnt <= 0;
         hs_cnt <= 0;
         de_off <= 4095;
         ck_hi  <= 0;
      end else begin
         de_cnt <= lcd_de ? de_cnt + 1 : 0;
         ck_hi  <= lcd_clk ? ck_hi + 1 : 0;
         hs_cnt <= lcd_hsync ? hs_cnt + 1 : 0;
         de_off <= lcd_de ? 0 : (de_off < 4095 ? de_off + 1 : de_off);
      end
   end

   // ------
   // assertions
   // ------
   apb_one_wait_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
      else $error("apb answer not after one wait");
   apb_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   apb_err_qual_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   row_width_a: assert property ($fell(lcd_de) |-> de_cnt == 640 * PIX_DIV)
      else $error("enable width is not 640 pixels");
   back_porch_a: assert property ($rose(lcd_de) |-> hs_cnt == 48 * PIX_DIV)
      else $error("enable not 48 pixels after hsync");
   front_porch_a: assert property ($fell(lcd_hsync) && de_off < 1000 |-> de_off == 16 * PIX_DIV)
      else $error("enable not 16 pixels before hsync");
   sync_clear_a: assert property (lcd_de |-> lcd_hsync)
      else $error("enable during hsync");
   blank_zero_a: assert property (!lcd_de |-> lcd_rgb == '0)
      else $error("pixel word outside enable");
   take_word_a: assert property (pix_take |-> lcd_de && lcd_rgb == $past(pix_in))
      else $error("pixel word differs from source");
   pix_clock_a: assert property ($fell(lcd_clk) |-> ck_hi == PIX_DIV / 2)
      else $error("pixel clock high time not half a pixel");
   step_space_a: assert property (!dim_step_n |=> dim_step_n [*3])
      else $error("dimmer steps too close");

   // main scenarios reached
   cov_row_c: cover property ($fell(lcd_de));
   cov_err_c: cover property (pslverr);
   cov_step_c: cover property (!dim_step_n);
endmodule // lpt_top_monitor

bind lpt_top lpt_top_monitor #(.PIX_DIV(PIX_DIV)) u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .pix_in(pix_in), .pix_take(pix_take), .lcd_clk(lcd_clk),
   .lcd_hsync(lcd_hsync), .lcd_de(lcd_de), .lcd_rgb(lcd_rgb), .dim_step_n(dim_step_n)
);

// File: dv/lpt_panel_model.sv
// lpt_panel_model.sv: behavioural panel and backlight dimmer at the far side
`timescale 1ns/1ps
module lpt_panel_model
   import lpt_pkg::*;
(
   input wire logic     lcd_clk,
   input wire logic     lcd_vsync,
   input wire logic     lcd_de,
   input wire lpt_rgb_t lcd_rgb,
   input wire logic     dim_up,
   input wire logic     dim_step_n
);
   lpt_rgb_t cap_q[$];
   int       px;
   int       rows_ok;
   int       rows_bad;
   int       wiper = 50;

   // ------
   // panel
   // ------
   // words kept raw; larger value means brighter
   // reversal never strapped, normal scan only
   always @(posedge lcd_clk) begin
      if (!lcd_vsync) begin
         px = 0;
         rows_ok = 0;
      end else if (lcd_de) begin
         cap_q.push_back(lcd_rgb);
         px = px + 1;
      end else if (px != 0) begin
         if (px == 640) rows_ok++;
         else rows_bad++;
         px = 0;
      end
   end

   // ------
   // dimmer wiper, clamps at both stops like the real part
   // ------
   // direction is read as the pulse ends, when it has surely settled
   always @(posedge dim_step_n) begin
      if (dim_up) wiper = (wiper < 99) ? wiper + 1 : wiper;
      else wiper = (wiper > 0) ? wiper - 1 : wiper;
   end
endmodule // lpt_panel_model

// File: dv/tb_lcd_panel_timing_generator.sv
// tb_lcd_panel_timing_generator.sv: self-checking bench of the panel timing generator
`timescale 1ns/1ps
module tb_lcd_panel_timing_generator
   import lpt_pkg::*;
();
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  panel_id;
   logic        key_pressed;
   lpt_rgb_t    pix_in;
   logic        pix_take;
   logic        lcd_clk;
   logic        lcd_hsync;
   logic        lcd_vsync;
   logic        lcd_de;
   lpt_rgb_t    lcd_rgb;
   logic        lamp_on;
   logic        dim_up;
   logic        dim_step_n;
   lpt_rgb_t    exp_q[$];
   logic [31:0] rd;
   logic        er;
   logic [3:0]  ids[3] = '{4'b1001, 4'b0001, 4'b0010};
   int          error_cnt;
   int          check_count;
   int          cyc;
   int          n;
   integer      seed = 32'haff2;

   // ------
   // clock, design and far side
   // ------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // short idle, pixel and step counts keep the run small
   lpt_top #(.IDLE_CYCLES(200), .PIX_DIV(2), .DIM_STEP(4)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .panel_id(panel_id), .key_pressed(key_pressed), .pix_in(pix_in), .pix_take(pix_take),
      .lcd_clk(lcd_clk), .lcd_hsync(lcd_hsync), .lcd_vsync(lcd_vsync), .lcd_de(lcd_de),
      .lcd_rgb(lcd_rgb), .lamp_on(lamp_on), .dim_up(dim_up), .dim_step_n(dim_step_n)
   );

   lpt_panel_model model (
      .lcd_clk(lcd_clk), .lcd_vsync(lcd_vsync), .lcd_de(lcd_de), .lcd_rgb(lcd_rgb),
      .dim_up(dim_up), .dim_step_n(dim_step_n)
   );

   // ------
   // tasks
   // ------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // holds the request until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 100);
      if (k == 100) error_cnt++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic end_of_test();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ------
   // pixel source and hang guard
   // ------
   // next word is offered the cycle after each take, which with PIX_DIV 2 is the next tick cycle
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 90000) begin
         error_cnt++;
         end_of_test();
      end
      if (pix_take === 1'b1) begin
         exp_q.push_back(pix_in);
         pix_in <= $random(seed);
      end
   end

   // ------
   // main sequence
   // ------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      key_pressed = 1'b0;
      panel_id = 4'b0001;
      pix_in = $random(seed);
      // unknown code first, the last id stays for the video run
      foreach (ids[i]) begin
         panel_id <= ids[i];
         presetn <= 1'b0;
         repeat (10) @(posedge pclk);
         presetn <= 1'b1;
         repeat (40) @(posedge pclk);
         apb(1'b0, LPT_ADDR_STATUS, '0);
         chk(rd[5:0], {2'b10, ids[i]});
      end
      // ctrl reset value, unmapped place, colour readback, clamp
      apb(1'b0, LPT_ADDR_CTRL, '0);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h014, '0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      n = $random(seed);
      apb(1'b1, LPT_ADDR_COLOUR, n);
      apb(1'b0, LPT_ADDR_COLOUR, '0);
      chk(rd, n & 32'h0003_ffff);
      apb(1'b1, LPT_ADDR_BRIGHT, 32'h0000_0078);
      apb(1'b0, LPT_ADDR_BRIGHT, '0);
      chk(rd, 32'h0000_0063);
      // backlight: keys keep it bright, idle halves it, a key restores it
      apb(1'b1, LPT_ADDR_BRIGHT, 32'h0000_003c);
      apb(1'b1, LPT_ADDR_CTRL, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      chk(lamp_on, 1'b1);
      repeat (8) begin
         key_pressed <= 1'b1;
         repeat (50) @(posedge pclk);
         key_pressed <= 1'b0;
         repeat (50) @(posedge pclk);
      end
      apb(1'b0, LPT_ADDR_STATUS, '0);
      chk(rd[15:7], {1'b1, 7'h3c, 1'b0});
      chk(model.wiper, 60);
      repeat (450) @(posedge pclk);
      apb(1'b0, LPT_ADDR_STATUS, '0);
      chk(rd[15:7], {1'b1, 7'h1e, 1'b1});
      chk(model.wiper, 30);
      key_pressed <= 1'b1;
      repeat (150) @(posedge pclk);
      apb(1'b0, LPT_ADDR_STATUS, '0);
      chk(rd[15:7], {1'b1, 7'h3c, 1'b0});
      // video: two full rows reach the panel
      apb(1'b1, LPT_ADDR_CTRL, 32'h0000_0003);
      n = 0;
      while (model.rows_ok < 2 && n < 70000) begin
         @(posedge pclk);
         n++;
      end
      chk(model.rows_bad, 0);
      chk(model.rows_ok, 2);
      chk(model.cap_q.size(), exp_q.size());
      foreach (exp_q[i]) chk(model.cap_q[i], exp_q[i]);
      // solid colour source: the next row carries only the colour register
      apb(1'b1, LPT_ADDR_COLOUR, 32'h0002_a5c3);
      apb(1'b1, LPT_ADDR_CTRL, 32'h0000_0007);
      while (model.rows_ok < 3 && n < 75000) begin
         @(posedge pclk);
         n++;
      end
      chk(model.cap_q.size(), exp_q.size() + 640);
      for (n = exp_q.size(); n < model.cap_q.size(); n++)
         chk(model.cap_q[n], 18'h2_a5c3);
      end_of_test();
   end
endmodule // tb_lcd_panel_timing_generator
